// ===== hw/pfl_top.sv
// pfl_top: pulse-input flow computer with 16-point linearization
// assumes pulse input and table inputs synchronous to i_clk
// Contract
// - flow equals input frequency times time scale over the table factor.
// - up to sixteen frequency and factor pairs form the correction curve.
// - a zero frequency in any entry after the first ends the table.
// - outside the table range the nearest end entry factor is used.
// - in range, the nearest entries above and below are interpolated.
// - factor is (f-lo)/(hi-lo)*(upper-lower)+lower.
`timescale 1ns/1ps
module pfl_top
   import pfl_pkg::*;
#(
   parameter int GATE_CYC = PFL_GATE_CYC
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // flowmeter pulse input
   input wire logic i_pulse,
   // linearization table, flat, entry k at bits k*W
   input wire logic [PFL_POINTS*PFL_FREQ_W-1:0] i_tbl_freq,
   input wire logic [PFL_POINTS*PFL_FACT_W-1:0] i_tbl_fact,
   input wire logic [PFL_SCALE_W-1:0] i_time_scale,
   // results
   output logic [PFL_FREQ_W-1:0] o_freq,
   output logic [PFL_FACT_W-1:0] o_interpolated_factor,
   output logic [PFL_FLOW_W-1:0] o_flow,
   output logic o_flow_valid
);
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   //--------------------------------------------------
   // table unpack and active-length detection
   //--------------------------------------------------
   logic [PFL_FREQ_W-1:0] tf [PFL_POINTS];
   logic [PFL_FACT_W-1:0] tk [PFL_POINTS];
   logic [PFL_POINTS-1:0] live;
   genvar g;
   generate
      for (g = 0; g < PFL_POINTS; g++)
      begin : g_ent
         assign tf[g] = i_tbl_freq[g*PFL_FREQ_W +: PFL_FREQ_W];
         assign tk[g] = i_tbl_fact[g*PFL_FACT_W +: PFL_FACT_W];
         if (g == 0)
         begin : g_first
            assign live[g] = 1'b1;
         end
         else
         begin : g_rest
            // zero frequency ends the table for this and later entries
            assign live[g] = live[g-1] && (tf[g] != PFL_FREQ_ZERO);
         end
      end
   endgenerate

   //--------------------------------------------------
   // gate and edge counter
   //--------------------------------------------------
   logic pulse_q, pulse_d;
   logic [PFL_CNT_W-1:0] gate_q, gate_d;
   logic [PFL_FREQ_W-1:0] edges_q, edges_d, freq_q, freq_d;
   logic gate_end;
   always_comb
   begin
      pulse_d = i_pulse;
      gate_end = (gate_q == PFL_CNT_W'(GATE_CYC - 1));
      gate_d = gate_end ? '0 : gate_q + 1'b1;
      edges_d = edges_q;
      freq_d = freq_q;
      if (gate_end)
      begin
         freq_d = edges_q + PFL_FREQ_W'(i_pulse && !pulse_q);
         edges_d = '0;
      end
      else if (i_pulse && !pulse_q)
         edges_d = edges_q + 1'b1;
   end
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pulse_q <= 1'b0;
         gate_q <= '0;
         edges_q <= '0;
         freq_q <= '0;
      end
      else
      begin
         pulse_q <= pulse_d;
         gate_q <= gate_d;
         edges_q <= edges_d;
         freq_q <= freq_d;
      end
   end

   //--------------------------------------------------
   // bracket search: nearest entries below and above
   //--------------------------------------------------
   logic have_lo, have_hi, lo_hit, hi_hit;
   logic [PFL_IDX_W-1:0] lo_idx, hi_idx, min_idx, max_idx;
   always_comb
   begin
      have_lo = 1'b0;
      have_hi = 1'b0;
      lo_hit = 1'b0;
      hi_hit = 1'b0;
      lo_idx = '0;
      hi_idx = '0;
      min_idx = '0;
      max_idx = '0;
      for (int k = 0; k < PFL_POINTS; k++)
      begin
         if (live[k])
         begin
            lo_hit = tf[k] <= freq_q;
            hi_hit = tf[k] >= freq_q;
            if (tf[k] < tf[min_idx])
               min_idx = PFL_IDX_W'(k);
            if (tf[k] > tf[max_idx])
               max_idx = PFL_IDX_W'(k);
            if (lo_hit && (!have_lo || tf[k] > tf[lo_idx]))
            begin
               lo_idx = PFL_IDX_W'(k);
               have_lo = 1'b1;
            end
            if (hi_hit && (!have_hi || tf[k] < tf[hi_idx]))
            begin
               hi_idx = PFL_IDX_W'(k);
               have_hi = 1'b1;
            end
         end
      end
      // clamp to nearest end entry
      if (!have_lo)
         lo_idx = min_idx;
      if (!have_hi)
         hi_idx = max_idx;
   end

   //--------------------------------------------------
   // sequencer with shared divider
   //--------------------------------------------------
   pfl_state_t st_q, st_d;
   logic [PFL_FACT_W-1:0] kn_q, kn_d, klo_q, klo_d, khi_q, khi_d;
   logic [PFL_FLOW_W-1:0] flow_q, flow_d;
   logic valid_q, valid_d, neg_q, neg_d;
   logic div_start, div_done;
   logic [PFL_PROD_W-1:0] div_num, div_den, div_quot;
   logic [PFL_FACT_W-1:0] kdiff;
   logic [PFL_FREQ_W-1:0] fspan, foff;
   logic [PFL_FREQ_W-1:0] flo_q, flo_d, fhi_q, fhi_d;
   always_comb
   begin
      st_d = st_q;
      kn_d = kn_q;
      klo_d = klo_q;
      khi_d = khi_q;
      flo_d = flo_q;
      fhi_d = fhi_q;
      neg_d = neg_q;
      flow_d = flow_q;
      valid_d = 1'b0;
      div_start = 1'b0;
      div_num = PFL_PROD_ZERO;
      div_den = PFL_PROD_ZERO;
      kdiff = neg_q ? klo_q - khi_q : khi_q - klo_q;
      fspan = fhi_q - flo_q;
      foff = freq_q - flo_q;
      unique case (st_q)
         PFL_IDLE:
            if (gate_end)
               st_d = PFL_SCAN;
         PFL_SCAN:
         begin
            klo_d = tk[lo_idx]; // lower_point_factor
            khi_d = tk[hi_idx]; // upper_point_factor
            flo_d = tf[lo_idx];
            fhi_d = tf[hi_idx];
            neg_d = tk[hi_idx] < tk[lo_idx];
            st_d = PFL_INTERP;
         end
         PFL_INTERP:
            if (fspan == PFL_FREQ_ZERO)
            begin
               // exact hit or clamped: no slope
               kn_d = klo_q;
               st_d = PFL_FLOW;
            end
            else
            begin
               // no restart on the done cycle, divider is shared
               div_start = !div_done;
               div_num = PFL_PROD_W'(foff) * PFL_PROD_W'(kdiff);
               div_den = PFL_PROD_W'(fspan);
               if (div_done)
               begin
                  kn_d = neg_q ? klo_q - PFL_FACT_W'(div_quot)
                               : klo_q + PFL_FACT_W'(div_quot);
                  st_d = PFL_FLOW;
               end
            end
         PFL_FLOW:
         begin
            div_start = !div_done;
            div_num = PFL_PROD_W'(freq_q) * PFL_PROD_W'(i_time_scale);
            div_den = PFL_PROD_W'(kn_q);
            if (div_done)
            begin
               // zero factor yields all ones from the divider
               flow_d = PFL_FLOW_W'(div_quot);
               st_d = PFL_DONE;
            end
         end
         PFL_DONE:
         begin
            valid_d = 1'b1;
            st_d = PFL_IDLE;
         end
      endcase
   end

   pfl_divider u_div (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_start(div_start),
      .i_num(div_num),
      .i_den(div_den),
      .o_busy(),
      .o_done(div_done),
      .o_quot(div_quot)
   );

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= PFL_IDLE;
         kn_q <= '0;
         klo_q <= '0;
         khi_q <= '0;
         flo_q <= '0;
         fhi_q <= '0;
         neg_q <= 1'b0;
         flow_q <= PFL_FLOW_RST;
         valid_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         kn_q <= kn_d;
         klo_q <= klo_d;
         khi_q <= khi_d;
         flo_q <= flo_d;
         fhi_q <= fhi_d;
         neg_q <= neg_d;
         flow_q <= flow_d;
         valid_q <= valid_d;
      end
   end

   assign o_freq = freq_q;
   assign o_interpolated_factor = kn_q;
   assign o_flow = flow_q;
   assign o_flow_valid = valid_q;
endmodule

// ===== hw/pfl_pkg.sv
// pfl_pkg: constants and types for the pulse flow linearizer
// assumes a single 125 MHz system clock
package pfl_pkg;
   localparam int PFL_CLK_HZ = 125000000;
   localparam int PFL_CLK_PERIOD_NS = 8;
   // gate interval in microseconds
   localparam int PFL_GATE_US = 100000;
   localparam int PFL_GATE_CYC = PFL_GATE_US * (PFL_CLK_HZ / 1000000);
   localparam int PFL_POINTS = 16;
   localparam int PFL_IDX_W = 4;
   localparam int PFL_FREQ_W = 24;
   localparam int PFL_FACT_W = 24;
   localparam int PFL_SCALE_W = 16;
   localparam int PFL_FLOW_W = 32;
   localparam int PFL_PROD_W = 48;
   localparam int PFL_CNT_W = 32;
   localparam logic [PFL_IDX_W-1:0] PFL_IDX_LAST = 4'hF;
   localparam logic [PFL_FREQ_W-1:0] PFL_FREQ_ZERO = 24'h000000;
   localparam logic [PFL_FLOW_W-1:0] PFL_FLOW_RST = 32'h00000000;
   localparam logic [PFL_PROD_W-1:0] PFL_PROD_ZERO = 48'h000000000000;
   localparam int PFL_DIV_STEPS = 48;
   localparam logic [5:0] PFL_DIV_LAST = 6'h2F;

   typedef enum logic [2:0] {
      PFL_IDLE,
      PFL_SCAN,
      PFL_INTERP,
      PFL_FLOW,
      PFL_DONE
   } pfl_state_t;
endpackage

// ===== hw/pfl_divider.sv
// pfl_divider: unsigned restoring divider, one quotient bit per cycle
// ignores i_start while o_busy is high
`timescale 1ns/1ps
module pfl_divider
   import pfl_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // request
   input wire logic i_start,
   input wire logic [PFL_PROD_W-1:0] i_num,
   input wire logic [PFL_PROD_W-1:0] i_den,
   // answer
   output logic o_busy,
   output logic o_done,
   output logic [PFL_PROD_W-1:0] o_quot
);
   logic [PFL_PROD_W-1:0] num_q, num_d, quot_q, quot_d, rem_q, rem_d;
   logic [PFL_PROD_W-1:0] den_q, den_d;
   logic [5:0] step_q, step_d;
   logic busy_q, busy_d, done_q, done_d;
   logic [PFL_PROD_W:0] trial;

   always_comb
   begin
      num_d = num_q;
      quot_d = quot_q;
      rem_d = rem_q;
      den_d = den_q;
      step_d = step_q;
      busy_d = busy_q;
      done_d = 1'b0;
      trial = {rem_q, num_q[PFL_PROD_W-1]};
      if (i_start && !busy_q)
      begin
         num_d = i_num;
         den_d = i_den;
         rem_d = PFL_PROD_ZERO;
         quot_d = PFL_PROD_ZERO;
         step_d = 6'h00;
         busy_d = 1'b1;
      end
      else if (busy_q)
      begin
         num_d = {num_q[PFL_PROD_W-2:0], 1'b0};
         if (trial >= {1'b0, den_q})
         begin
            rem_d = PFL_PROD_W'(trial - {1'b0, den_q});
            quot_d = {quot_q[PFL_PROD_W-2:0], 1'b1};
         end
         else
         begin
            rem_d = trial[PFL_PROD_W-1:0];
            quot_d = {quot_q[PFL_PROD_W-2:0], 1'b0};
         end
         step_d = step_q + 6'h01;
         if (step_q == PFL_DIV_LAST)
         begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         num_q <= PFL_PROD_ZERO;
         quot_q <= PFL_PROD_ZERO;
         rem_q <= PFL_PROD_ZERO;
         den_q <= PFL_PROD_ZERO;
         step_q <= 6'h00;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else
      begin
         num_q <= num_d;
         quot_q <= quot_d;
         rem_q <= rem_d;
         den_q <= den_d;
         step_q <= step_d;
         busy_q <= busy_d;
         done_q <= done_d;
      end
   end

   assign o_busy = busy_q;
   assign o_done = done_q;
   assign o_quot = quot_q;
endmodule

// ===== bench/pfl_flowmeter_model.sv
// pfl_flowmeter_model: pulse-output flowmeter stand-in
// assumes i_period of 0 (still) or at least 2 clock cycles
`timescale 1ns/1ps
module pfl_flowmeter_model
(
   // clock
   input wire logic i_clk,
   // pulse spacing in clock cycles, 0 for no flow
   input wire logic [7:0] i_period,
   // pulse line to the flow computer
   output logic o_pulse
);
   // ---------------------------------------------
   // one-cycle pulse every i_period cycles
   // ---------------------------------------------
   int cnt = 0;
   initial o_pulse = 1'b0;
   always @(posedge i_clk)
   begin
      cnt <= (cnt + 1 >= i_period) ? 0 : cnt + 1;
      o_pulse <= #1 (i_period != 8'h00) && (cnt == 0);
   end
endmodule

// ===== bench/pfl_top_asserts.sv
// pfl_top_asserts: timing and result checks on the flow computer
// assumes one clock domain and gate length GATE_CYC
`timescale 1ns/1ps
module pfl_top_asserts
   import pfl_pkg::*;
#(
   parameter int GATE_CYC = PFL_GATE_CYC
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // inputs
   input wire logic i_pulse,
   input wire logic [PFL_POINTS*PFL_FREQ_W-1:0] i_tbl_freq,
   input wire logic [PFL_POINTS*PFL_FACT_W-1:0] i_tbl_fact,
   input wire logic [PFL_SCALE_W-1:0] i_time_scale,
   // results
   input wire logic [PFL_FREQ_W-1:0] o_freq,
   input wire logic [PFL_FACT_W-1:0] o_interpolated_factor,
   input wire logic [PFL_FLOW_W-1:0] o_flow,
   input wire logic o_flow_valid
);
   // ---------------------------------------------
   // helper counters
   // ---------------------------------------------
   logic [31:0] vcnt_q, fcnt_q;
   logic vseen_q, fseen_q;
   logic [63:0] prod_lo, prod_hi, num;
   assign prod_lo = 64'(o_flow) * 64'(o_interpolated_factor);
   assign prod_hi = prod_lo + 64'(o_interpolated_factor);
   assign num = 64'(o_freq) * 64'(i_time_scale);
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         vcnt_q <= 32'h0;
         fcnt_q <= 32'h0;
         vseen_q <= 1'b0;
         fseen_q <= 1'b0;
      end
      else
      begin
         vcnt_q <= o_flow_valid ? 32'h0 : vcnt_q + 32'h1;
         fcnt_q <= $changed(o_freq) ? 32'h0 : fcnt_q + 32'h1;
         vseen_q <= vseen_q | o_flow_valid;
         fseen_q <= fseen_q | $changed(o_freq);
      end
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   valid_one_cycle_a: assert property (o_flow_valid |=> !o_flow_valid)
      else $error("flow valid longer than one cycle");
   flow_then_valid_a: assert property ($changed(o_flow) |=> o_flow_valid)
      else $error("flow changed without valid");
   flow_quotient_a: assert property (o_flow_valid &&
      o_interpolated_factor != 24'h000000 |-> prod_lo <= num && num < prod_hi)
      else $error("flow is not freq times scale over factor");
   fact_then_valid_a: assert property ($changed(o_interpolated_factor)
      |-> ##[1:150] o_flow_valid)
      else $error("factor changed without a result");
   fact_settled_a: assert property ($changed(o_interpolated_factor)
      |=> $stable(o_interpolated_factor) [*8])
      else $error("factor unsettled");
   freq_then_valid_a: assert property ($changed(o_freq)
      |-> ##[1:150] o_flow_valid)
      else $error("no result after gate");
   freq_on_gate_a: assert property (fseen_q && $changed(o_freq)
      |-> (fcnt_q + 32'h1) % GATE_CYC == 0)
      else $error("frequency changed off the gate");
   valid_spacing_a: assert property (vseen_q && o_flow_valid
      |-> vcnt_q >= GATE_CYC / 2)
      else $error("results closer than a gate");
   valid_alive_a: assert property (vseen_q |-> vcnt_q < 2 * GATE_CYC)
      else $error("result missing for a gate");
   cover property (o_flow_valid && o_freq == 24'h000000);
   cover property (o_flow_valid && o_freq > 24'h000028);
   cover property ($changed(o_interpolated_factor));
endmodule
bind pfl_top pfl_top_asserts #(.GATE_CYC(GATE_CYC)) u_asserts (
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_pulse(i_pulse),
   .i_tbl_freq(i_tbl_freq), .i_tbl_fact(i_tbl_fact),
   .i_time_scale(i_time_scale), .o_freq(o_freq),
   .o_interpolated_factor(o_interpolated_factor),
   .o_flow(o_flow), .o_flow_valid(o_flow_valid));

// ===== bench/pulse_flow_linearizer_tb.sv
// pulse_flow_linearizer_tb: table-driven flow computer bench
// assumes gate of 200 cycles and pulse periods dividing it
`timescale 1ns/1ps
module pulse_flow_linearizer_tb;
   import pfl_pkg::*;
   typedef struct {int per; logic dec; logic [23:0] fr; logic [23:0] fa;
      logic [31:0] fl;} pfl_row_t;
   logic i_clk, i_arst_n, i_pulse;
   logic [383:0] i_tbl_freq, i_tbl_fact;
   logic [15:0] i_time_scale;
   logic [23:0] o_freq, o_interpolated_factor;
   logic [31:0] o_flow;
   logic o_flow_valid;
   logic [7:0] per;
   int n_mismatch = 0;
   int checks = 0;
   pfl_row_t rows [8] = '{
      '{20, 0, 24'h00000A, 24'h000064, 32'h00000078},
      '{10, 0, 24'h000014, 24'h0000C8, 32'h00000078},
      '{8, 0, 24'h000019, 24'h00012C, 32'h00000064},
      '{5, 0, 24'h000028, 24'h000258, 32'h00000050},
      '{4, 0, 24'h000032, 24'h000258, 32'h00000064},
      '{25, 0, 24'h000008, 24'h000064, 32'h00000060},
      '{0, 0, 24'h000000, 24'h000064, 32'h00000000},
      '{8, 1, 24'h000019, 24'h00015E, 32'h00000055}};
   pfl_top #(.GATE_CYC(200)) u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_pulse(i_pulse), .i_tbl_freq(i_tbl_freq), .i_tbl_fact(i_tbl_fact),
      .i_time_scale(i_time_scale), .o_freq(o_freq),
      .o_interpolated_factor(o_interpolated_factor), .o_flow(o_flow),
      .o_flow_valid(o_flow_valid));
   pfl_flowmeter_model u_meter (.i_clk(i_clk), .i_period(per),
      .o_pulse(i_pulse));
   initial i_clk = 1'b0;
   always #4 i_clk = ~i_clk;
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task complete_run;
      if (n_mismatch == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] got, exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %0d seen %0d", name, exp, got);
      end
   endtask
   // outputs stay cleared until the first gate closes
   task check_idle;
      repeat (2) @(posedge i_clk);
      #1;
      chk("idle freq", {8'h00, o_freq}, 32'h0);
      chk("idle fact", {8'h00, o_interpolated_factor}, 32'h0);
      chk("idle flow", o_flow, 32'h0);
      chk("idle valid", {31'h0, o_flow_valid}, 32'h0);
   endtask
   // three pairs, ascending, zero ends table before a stray entry
   task set_tbl(input logic dec);
      logic [383:0] f, k;
      f = '0;
      k = '0;
      f[71:0] = {24'h000028, 24'h000014, 24'h00000A};
      f[119:96] = 24'h000005;
      k[71:0] = dec ? {24'h0000C8, 24'h000190, 24'h000258}
                    : {24'h000258, 24'h0000C8, 24'h000064};
      k[119:96] = 24'h002328;
      i_tbl_freq = f;
      i_tbl_fact = k;
   endtask
   task wait_valid;
      int n;
      for (n = 0; n < 400; n++)
      begin
         @(posedge i_clk);
         #1;
         if (o_flow_valid === 1'b1)
            break;
      end
      if (n == 400)
      begin
         n_mismatch++;
         complete_run;
      end
   endtask
   // first result may mix old and new settings
   task run_row(input pfl_row_t r);
      set_tbl(r.dec);
      per = r.per[7:0];
      repeat (3) wait_valid;
      chk("freq", {8'h00, o_freq}, {8'h00, r.fr});
      chk("factor", {8'h00, o_interpolated_factor},
         {8'h00, r.fa});
      chk("flow", o_flow, r.fl);
   endtask
   // ---------------------------------------------
   // sequence
   // ---------------------------------------------
   initial
   begin
      i_arst_n = 1'b0;
      per = 8'h00;
      i_time_scale = 16'h04B0;
      set_tbl(1'b0);
      repeat (3) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      check_idle;
      foreach (rows[i])
         run_row(rows[i]);
      i_arst_n = 1'b0;
      repeat (3) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      check_idle;
      run_row(rows[2]);
      complete_run;
   end
endmodule
